// ---- hdl/ciu_cmp_core.sv ----
// native compare core: one less-than, optionally inverted to give ge
// assumes operands already ordered and extended by the decode stage
`timescale 1ns/100ps
module ciu_cmp_core
  import ciu_pkg::*;
(
  ciu_cmp_if.core cmp
);
  logic lt;

  // two subtract-free less-thans, one signed and one unsigned, picked by is_signed, keep area small
  always_comb begin
    if (cmp.is_signed) begin
      lt = $signed(cmp.lhs) < $signed(cmp.rhs);
    end else begin
      lt = cmp.lhs < cmp.rhs;
    end
  end

  assign cmp.result = lt ^ cmp.invert;
endmodule : ciu_cmp_core

// ---- hdl/ciu_cmp_if.sv ----
// carrier between the decode stage and the compare core
// assumes one clock domain; purely combinational signals
`timescale 1ns/100ps
interface ciu_cmp_if;
  import ciu_pkg::*;
  logic [DATA_W-1:0] lhs;
  logic [DATA_W-1:0] rhs;
  logic              is_signed;
  logic              invert;
  logic              result;

  modport core (input lhs, input rhs, input is_signed, input invert, output result);
  modport user (output lhs, output rhs, output is_signed, output invert, input result);
endinterface : ciu_cmp_if

// ---- hdl/ciu_compare_unit.sv ----
// compare instruction unit: decodes compare forms, writes 0 or 1 back
// assumes operand values are read from the register file in the issue cycle
`timescale 1ns/100ps
module ciu_compare_unit
  import ciu_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              issue_valid_i,
  input  wire logic [31:0]       instr_i,
  input  wire logic [WIDTH-1:0]  first_source_register_i,
  input  wire logic [WIDTH-1:0]  second_source_or_destination_i,
  output logic                   wr_en_o,
  output logic [IDX_W-1:0]       wr_idx_o,
  output logic [WIDTH-1:0]       wr_data_o
);
  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (WIDTH != DATA_W) begin : g_bad_width
    $error("compare unit serves only the 32-bit datapath");
  end

  // ---------------------------------------------------------------
  // field extraction
  // ---------------------------------------------------------------
  logic [OPC_W-1:0] opcode;
  logic [OPC_W-1:0] opx;
  logic [IMM_W-1:0] encoded_immediate_field;
  logic [IDX_W-1:0] first_source_idx;
  logic [IDX_W-1:0] second_source_idx;
  logic [IDX_W-1:0] register_form_destination;

  assign opcode                    = instr_i[OPC_HI:OPC_LO];
  assign encoded_immediate_field   = instr_i[IMM_HI:IMM_LO];
  assign first_source_idx          = instr_i[SRC_A_HI:SRC_A_LO];
  assign second_source_idx         = instr_i[SRC_B_HI:SRC_B_LO];
  assign register_form_destination = instr_i[DST_C_HI:DST_C_LO];
  assign opx                       = instr_i[OPX_HI:OPX_LO];

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  ciu_cmp_if cmp ();

  logic             hit;
  logic [IDX_W-1:0] dest;

  always_comb begin
    hit           = 1'b0;
    dest          = second_source_idx;
    cmp.lhs       = first_source_register_i;
    cmp.rhs       = second_source_or_destination_i;
    cmp.is_signed = 1'b0;
    cmp.invert    = 1'b0;
    case (opcode)
      OPC_GEUI: begin
        hit        = 1'b1;
        cmp.rhs    = {16'h0000, encoded_immediate_field};
        cmp.invert = 1'b1;
      end
      OPC_GEI: begin
        // greater-than immediate arrives here with the immediate already plus one
        hit           = 1'b1;
        cmp.rhs       = {{16{encoded_immediate_field[IMM_W-1]}},
                         encoded_immediate_field};
        cmp.is_signed = 1'b1;
        cmp.invert    = 1'b1;
      end
      OPC_RTYPE: begin
        dest = register_form_destination;
        case (opx)
          OPX_GE: begin
            // le reaches here with the register indices exchanged
            hit           = 1'b1;
            cmp.is_signed = 1'b1;
            cmp.invert    = 1'b1;
          end
          OPX_GEU: begin
            hit        = 1'b1;
            cmp.invert = 1'b1;
          end
          OPX_LT: begin
            // gt reaches here with the register indices exchanged
            hit           = 1'b1;
            cmp.is_signed = 1'b1;
          end
          OPX_LTU: begin
            hit = 1'b1;
          end
          default: begin
            hit = 1'b0;
          end
        endcase
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  ciu_cmp_core u_core (
    .cmp (cmp.core)
  );

  // ---------------------------------------------------------------
  // write-back register
  // ---------------------------------------------------------------
  // enable cleared by reset: a stale pulse would write a random register
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wr_en_o <= 1'b0;
    end else begin
      wr_en_o <= issue_valid_i & hit;
    end
  end

  // data and index held when nothing issues, so the port stays quiet
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wr_idx_o  <= WR_IDX_RST;
      wr_data_o <= WR_DATA_RST;
    end else if (issue_valid_i && hit) begin
      wr_idx_o  <= dest;
      wr_data_o <= {{(WIDTH-1){1'b0}}, cmp.result};
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking dc @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  geui_result_a: assert property (
    issue_valid_i && opcode == OPC_GEUI |=> wr_en_o && wr_data_o ==
      {31'h0, $past(first_source_register_i) >= {16'h0000, $past(instr_i[21:6])}})
    else $error("unsigned ge immediate result wrong");

  geui_dest_a: assert property (
    issue_valid_i && instr_i[5:0] == 6'h28 |=> wr_en_o && wr_idx_o == $past(instr_i[26:22]))
    else $error("unsigned ge immediate wrote wrong register");

  lt_signed_a: assert property (
    issue_valid_i && opcode == OPC_RTYPE && opx == OPX_LT |=> wr_data_o[0] ==
      ($signed($past(first_source_register_i)) < $signed($past(second_source_or_destination_i))))
    else $error("signed lt result wrong");

  gei_signed_a: assert property (
    issue_valid_i && opcode == OPC_GEI |=> wr_data_o[0] ==
      ($signed($past(first_source_register_i)) >= $signed($past(instr_i[21:6]))))
    else $error("signed ge immediate result wrong");

  ltu_result_a: assert property (
    issue_valid_i && opcode == OPC_RTYPE && opx == OPX_LTU |=> wr_data_o ==
      {31'h0, $past(first_source_register_i) < $past(second_source_or_destination_i)})
    else $error("unsigned lt result wrong");

  ge_signed_a: assert property (
    issue_valid_i && opcode == OPC_RTYPE && opx == OPX_GE |=> wr_en_o
      && wr_idx_o == $past(instr_i[21:17]) && wr_data_o[0] ==
      ($signed($past(first_source_register_i)) >= $signed($past(second_source_or_destination_i))))
    else $error("signed ge result wrong");

  no_issue_quiet_a: assert property (
    !issue_valid_i |=> !wr_en_o && $stable(wr_data_o) && $stable(wr_idx_o))
    else $error("write-back moved without an issue");

  // ---------------------------------------------------------------
  // destination and width checks
  // ---------------------------------------------------------------
  gei_dest_a: assert property (
    issue_valid_i && opcode == OPC_GEI |=> wr_en_o
      && wr_idx_o == $past(instr_i[SRC_B_HI:SRC_B_LO]))
    else $error("signed ge immediate wrote wrong register");

  geu_result_a: assert property (
    issue_valid_i && opcode == OPC_RTYPE && opx == OPX_GEU |=> wr_en_o
      && wr_idx_o == $past(instr_i[DST_C_HI:DST_C_LO]) && wr_data_o ==
      {31'h0, $past(first_source_register_i) >= $past(second_source_or_destination_i)})
    else $error("unsigned ge result wrong");

  result_bit_only_a: assert property (
    ~|wr_data_o[WIDTH-1:1])
    else $error("write-back data has upper bits set");

  // ---------------------------------------------------------------
  // swapped forms, restated as the producer means them
  // ---------------------------------------------------------------
  // the device only ever sees native lt and ge, so a swap slip shows up here
  gt_swapped_a: assert property (
    issue_valid_i && opcode == OPC_RTYPE && opx == OPX_LT |=> wr_en_o
      && wr_idx_o == $past(instr_i[DST_C_HI:DST_C_LO]) && wr_data_o[0] ==
      ($signed($past(second_source_or_destination_i)) > $signed($past(first_source_register_i))))
    else $error("signed gt via swapped lt wrong");

  gtu_swapped_a: assert property (
    issue_valid_i && opcode == OPC_RTYPE && opx == OPX_LTU |=> wr_en_o
      && wr_idx_o == $past(instr_i[DST_C_HI:DST_C_LO]) && wr_data_o[0] ==
      ($past(second_source_or_destination_i) > $past(first_source_register_i)))
    else $error("unsigned gt via swapped ltu wrong");

  le_swapped_a: assert property (
    issue_valid_i && opcode == OPC_RTYPE && opx == OPX_GE |=> wr_en_o
      && wr_idx_o == $past(instr_i[DST_C_HI:DST_C_LO]) && wr_data_o[0] ==
      ($signed($past(second_source_or_destination_i)) <= $signed($past(first_source_register_i))))
    else $error("signed le via swapped ge wrong");

  // ---------------------------------------------------------------
  // refused encodings
  // ---------------------------------------------------------------
  // an unknown encoding must not disturb the register file, not even the index
  bad_opcode_quiet_a: assert property (
    issue_valid_i && opcode != OPC_GEUI && opcode != OPC_GEI && opcode != OPC_RTYPE
      |=> !wr_en_o && $stable(wr_data_o) && $stable(wr_idx_o))
    else $error("unknown opcode caused a write");

  bad_opx_quiet_a: assert property (
    issue_valid_i && opcode == OPC_RTYPE && opx != OPX_GE && opx != OPX_GEU
      && opx != OPX_LT && opx != OPX_LTU |=> !wr_en_o && $stable(wr_data_o) && $stable(wr_idx_o))
    else $error("unknown register-form compare caused a write");
endmodule : ciu_compare_unit

// ---- hdl/ciu_pkg.sv ----
// constants for the compare instruction unit: opcodes, field positions, widths
// assumes a 32-bit instruction word delivered by the decoder each issue cycle
//
// Behaviour
// - unsigned ge immediate zero-extends, writes one or zero
// - opcode 0x28 selects unsigned ge immediate
// - signed gt is signed lt, operands swapped
// - signed gt immediate sign-extends, writes one or zero
// - unsigned gt is unsigned lt, operands swapped
// - signed le is signed ge, operands swapped
package ciu_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int IMM_W  = 16;
  localparam int IDX_W  = 5;
  localparam int OPC_W  = 6;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SRC_A_HI = 31;
  localparam int SRC_A_LO = 27;
  localparam int SRC_B_HI = 26;
  localparam int SRC_B_LO = 22;
  localparam int DST_C_HI = 21;
  localparam int DST_C_LO = 17;
  localparam int OPX_HI   = 16;
  localparam int OPX_LO   = 11;
  localparam int IMM_HI   = 21;
  localparam int IMM_LO   = 6;
  localparam int OPC_HI   = 5;
  localparam int OPC_LO   = 0;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [OPC_W-1:0] OPC_GEUI  = 6'h28;
  localparam logic [OPC_W-1:0] OPC_GEI   = 6'h08;
  localparam logic [OPC_W-1:0] OPC_RTYPE = 6'h3A;
  localparam logic [OPC_W-1:0] OPX_GE    = 6'h08;
  localparam logic [OPC_W-1:0] OPX_GEU   = 6'h28;
  localparam logic [OPC_W-1:0] OPX_LT    = 6'h10;
  localparam logic [OPC_W-1:0] OPX_LTU   = 6'h30;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] WR_DATA_RST = 32'h0000_0000;
  localparam logic [IDX_W-1:0]  WR_IDX_RST  = 5'h00;
endpackage : ciu_pkg

// ---- tb/ciu_rf_model.sv ----
// far-side model: register file feeding operands, taking write-back
// assumes the bench preloads the two slots named by the instruction
`timescale 1ns/100ps
module ciu_rf_model
  import ciu_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              load_i,
  input  wire logic [31:0]       instr_i,
  input  wire logic [DATA_W-1:0] load_a_i,
  input  wire logic [DATA_W-1:0] load_b_i,
  input  wire logic              wr_en_i,
  input  wire logic [IDX_W-1:0]  wr_idx_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  output logic      [DATA_W-1:0] op_a_o,
  output logic      [DATA_W-1:0] op_b_o
);
  logic [DATA_W-1:0] regs_q [32];

  // preload wins over write-back so the next test sees its own operands
  always_ff @(posedge ref_clk_i) begin
    if (load_i) begin
      regs_q[instr_i[SRC_A_HI:SRC_A_LO]] <= load_a_i;
      regs_q[instr_i[SRC_B_HI:SRC_B_LO]] <= load_b_i;
    end else if (wr_en_i) begin
      regs_q[wr_idx_i] <= wr_data_i;
    end
  end
  assign op_a_o = regs_q[instr_i[SRC_A_HI:SRC_A_LO]];
  assign op_b_o = regs_q[instr_i[SRC_B_HI:SRC_B_LO]];
endmodule : ciu_rf_model

// ---- tb/tb.sv ----
// self-checking bench for the compare unit, random and corner operands
// assumes one issue every third cycle; register file model on far side
`timescale 1ns/100ps
module tb;
  import ciu_pkg::*;
  logic              ref_clk_i = 1'b0;
  logic              sys_rst_i = 1'b1;
  logic              issue_valid_i = 1'b0;
  logic              load = 1'b0;
  logic [31:0]       instr_i = 32'h0;
  logic [DATA_W-1:0] load_a = 32'h0, load_b = 32'h0, op_a, op_b, wr_data_o;
  logic              wr_en_o;
  logic [IDX_W-1:0]  wr_idx_o;
  int                errors = 0, comparisons = 0, cycles = 0;

  ciu_compare_unit ciu_compare_unit_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .issue_valid_i(issue_valid_i), .instr_i(instr_i), .first_source_register_i(op_a),
    .second_source_or_destination_i(op_b), .wr_en_o(wr_en_o), .wr_idx_o(wr_idx_o),
    .wr_data_o(wr_data_o));
  ciu_rf_model ciu_rf_model_i (.ref_clk_i(ref_clk_i), .load_i(load), .instr_i(instr_i),
    .load_a_i(load_a), .load_b_i(load_b), .wr_en_i(wr_en_o), .wr_idx_i(wr_idx_o),
    .wr_data_i(wr_data_o), .op_a_o(op_a), .op_b_o(op_b));

  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // run needs about 1300 cycles; a hang is cut well beyond that
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] ienc(logic [4:0] a, logic [4:0] b, logic [15:0] e,
                                       logic [5:0] opc);
    return {a, b, e, opc};
  endfunction : ienc
  function automatic logic [31:0] renc(logic [4:0] a, logic [4:0] b, logic [4:0] c,
                                       logic [5:0] opx);
    return {a, b, c, opx, 5'h00, OPC_RTYPE};
  endfunction : renc
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
    comparisons++;
    if (seen !== want) begin
      errors++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // preload, issue, then look at the single write-back cycle
  task automatic issue(input logic [31:0] ins, input logic [31:0] va, input logic [31:0] vb,
                       input logic [4:0] dst, input logic res, input logic ok);
    logic [4:0]  idx0;
    logic [31:0] dat0;
    idx0 = wr_idx_o;
    dat0 = wr_data_o;
    @(posedge ref_clk_i);
    instr_i <= ins;
    load <= 1'b1;
    load_a <= va;
    load_b <= vb;
    @(posedge ref_clk_i);
    load <= 1'b0;
    issue_valid_i <= 1'b1;
    @(posedge ref_clk_i);
    issue_valid_i <= 1'b0;
    #1;
    check({31'h0, wr_en_o}, {31'h0, ok});
    check({27'h0, wr_idx_o}, {27'h0, ok ? dst : idx0});
    check(wr_data_o, ok ? {31'h0, res} : dat0);
  endtask : issue

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [4:0]         a, b, c;
    logic [15:0]        e;
    logic [31:0]        va, vb;
    logic signed [32:0] s;
    a = 5'($urandom(32'hE8A05ECF));
    repeat (3) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    check({wr_en_o, wr_idx_o, wr_data_o[25:0]}, 32'h0);
    for (int n = 0; n < 420; n++) begin
      a = 5'($urandom);
      b = a + 5'h01 + 5'($urandom % 30);
      c = 5'($urandom);
      va = $urandom;
      vb = (n % 5 == 0) ? va : $urandom;
      if (n % 3 == 0) va = 32'h8000_0000 ^ (32'(n % 2) - 32'h1);
      e = (n % 7 == 0) ? va[15:0] : 16'($urandom);
      if (n % 13 == 0) e = 16'h8000;
      case (n % 12)
        0: issue(ienc(a, b, e, OPC_GEUI), va, vb, b, va >= {16'h0, e}, 1'b1);
        1: issue(ienc(a, b, e, OPC_GEI), va, vb, b, $signed(va) >= $signed(e), 1'b1);
        2: issue(renc(a, b, c, OPX_GE), va, vb, c, $signed(va) >= $signed(vb), 1'b1);
        3: issue(renc(a, b, c, OPX_GEU), va, vb, c, va >= vb, 1'b1);
        4: issue(renc(a, b, c, OPX_LT), va, vb, c, $signed(va) < $signed(vb), 1'b1);
        5: issue(renc(a, b, c, OPX_LTU), va, vb, c, va < vb, 1'b1);
        6: issue(renc(b, a, c, OPX_LT), vb, va, c, $signed(va) > $signed(vb), 1'b1);
        7: issue(renc(b, a, c, OPX_LTU), vb, va, c, va > vb, 1'b1);
        8: issue(renc(b, a, c, OPX_GE), vb, va, c, $signed(va) <= $signed(vb), 1'b1);
        9: begin
          s = $signed(e) - 33'sd1;
          issue(ienc(a, b, 16'(s + 1), OPC_GEI), va, vb, b, $signed(va) > s, 1'b1);
        end
        10: begin
          s = {17'h0, (e == 16'h0) ? 16'h0001 : e} - 33'sd1;
          issue(ienc(a, b, 16'(s + 1), OPC_GEUI), va, vb, b, {1'b0, va} > s, 1'b1);
        end
        default: issue((n % 24 == 11) ? ienc(a, b, e, 6'h01) : renc(a, b, c, 6'h00),
                       va, vb, b, 1'b0, 1'b0);
      endcase
    end
    tally_and_finish();
  end
endmodule : tb
